/* hdl/sswd_pkg.sv */
// Constants for the host-side controller of the supply supervisor.
// Assumes a 125 MHz core clock; times are kept in their own units.
package sswd_pkg;
  localparam int CLK_MHZ              = 125;
  localparam int MANUAL_MIN_PULSE_NS  = 1000;
  localparam int ACTIVITY_MIN_HOLD_NS = 100;
  localparam int SUPPLY_FALL_US       = 30;
  // Least times round up to whole cycles
  localparam int MANUAL_MIN_CYC =
    (MANUAL_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACTIVITY_HOLD_CYC =
    (ACTIVITY_MIN_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int SUPPLY_FALL_CYC = SUPPLY_FALL_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int SYNC_STAGES = 3;
  // Default strobe interval in cycles, well below any watchdog timeout
  localparam int STROBE_PERIOD_CYC = 12500;
endpackage : sswd_pkg

/* hdl/sswd_host.sv */
// Host-side controller facing the supply supervisor's pins.
// Assumes the reset line is open drain with an external pull-up and
// that the supervisor's inputs are sampled asynchronously to this clock.
module sswd_host
  import sswd_pkg::*;
#(
  parameter int STROBE_PERIOD = sswd_pkg::STROBE_PERIOD_CYC,
  parameter int MANUAL_CYC    = sswd_pkg::MANUAL_MIN_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic clk_en_i,
  input  wire logic manual_req_i,      // Pulse: request a manual reset
  input  wire logic strobe_en_i,       // Level: keep watchdog fed
  input  wire logic assert_reset_i,    // Level: host pulls reset line
  input  wire logic reset_line_i,      // Sampled level of shared reset line
  output logic      manual_reset_in_n_o,
  output logic      manual_reset_oe_o,
  output logic      activity_strobe_in_o,
  output logic      activity_oe_o,
  output logic      reset_line_o,
  output logic      reset_line_oe_o,
  output logic      target_in_reset_o,
  output logic      manual_busy_o
);
  import sswd_pkg::*;

  // Step a counter down by one and rest at zero
  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = v;
    if (v != '0) begin
      r = v - 1'b1;
    end
    return r;
  endfunction : dec_sat

  // Counter load that never falls below a least count
  function automatic logic [CNT_W-1:0] floor_load(input int want, input int least);
    int r;
    r = want;
    if (want < least) begin
      r = least;
    end
    return CNT_W'(r);
  endfunction : floor_load

  // The two late sync stages hold the same level
  function automatic logic stages_agree(input logic [SYNC_STAGES-1:0] s);
    return s[SYNC_STAGES-1] == s[SYNC_STAGES-2];
  endfunction : stages_agree

  // Counter loads; a parameter set too small is raised to the least legal
  // count, so a misconfigured instance still meets the pin timing
  localparam logic [CNT_W-1:0] MAN_LOAD = floor_load(MANUAL_CYC, MANUAL_MIN_CYC);
  localparam logic [CNT_W-1:0] STB_LOAD = floor_load(STROBE_PERIOD, ACTIVITY_HOLD_CYC);
  localparam logic [CNT_W-1:0] MAN_LAST = CNT_W'(1);

  // Reset line synchroniser and the filtered level
  logic [SYNC_STAGES-1:0] rst_sync;
  logic [SYNC_STAGES-1:0] next_rst_sync;
  logic                   seen_low;
  logic                   next_seen_low;

  // Manual pulse width counter and drive
  logic [CNT_W-1:0]       man_cnt;
  logic [CNT_W-1:0]       next_man_cnt;
  logic                   man_drv;
  logic                   next_man_drv;

  // Strobe interval counter, level and enable
  logic [CNT_W-1:0]       stb_cnt;
  logic [CNT_W-1:0]       next_stb_cnt;
  logic                   stb_lvl;
  logic                   next_stb_lvl;
  logic                   stb_oe;
  logic                   next_stb_oe;

  // Host sink on the shared reset line
  logic                   rst_drv;
  logic                   next_rst_drv;

  // Reset line sampling: newest stage takes the pin, the others shift up.
  // The line is asynchronous to this clock; a single stage could go
  // metastable, so only a level that two settled stages agree on counts.
  always_comb begin
    next_rst_sync = {rst_sync[SYNC_STAGES-2:0], reset_line_i};
    next_seen_low = seen_low;
    // Stages two and three agree: take their level
    if (stages_agree(rst_sync)) begin
      next_seen_low = ~rst_sync[SYNC_STAGES-1];           // Low line, target held
    end
  end

  // Line sampling registers; stages start at the pulled-up idle level so
  // that no false low is seen straight after reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_sync <= '1;
      seen_low <= 1'b0;
    end else if (clk_en_i) begin
      rst_sync <= next_rst_sync;
      seen_low <= next_seen_low;
    end
  end

  // Manual pulse: sink the input for the full width and refuse requests
  // meanwhile, so a second request can never stretch or split a pulse.
  // A pulse shorter than the least width could be taken as a glitch.
  always_comb begin
    next_man_cnt = dec_sat(man_cnt);
    next_man_drv = man_drv;
    // Last counted cycle: let the pull-up take the input back high
    if (man_cnt <= MAN_LAST) begin
      next_man_drv = 1'b0;
    end
    // A request is only taken while idle; a busy one is dropped
    if (manual_req_i && !man_drv) begin
      next_man_cnt = MAN_LOAD;
      next_man_drv = 1'b1;
    end
  end

  // Manual pulse registers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      man_cnt <= '0;
      man_drv <= 1'b0;
    end else if (clk_en_i) begin
      man_cnt <= next_man_cnt;
      man_drv <= next_man_drv;
    end
  end

  // Strobe: toggle well inside the watchdog interval, float when disabled.
  // Each level is held for a whole load, never under the least hold, so
  // every toggle is seen as a valid edge by the far side.
  always_comb begin
    next_stb_lvl = stb_lvl;
    next_stb_oe  = strobe_en_i;
    next_stb_cnt = dec_sat(stb_cnt);
    if (!strobe_en_i) begin
      // Disabled: three-state the pin and rearm a full interval
      next_stb_cnt = STB_LOAD;
    end else if (stb_cnt == '0) begin
      // Interval used up: flip the level and start the next one
      next_stb_lvl = ~stb_lvl;
      next_stb_cnt = STB_LOAD;
    end
  end

  // Strobe registers; the pin starts three-stated
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      stb_cnt <= '0;
      stb_lvl <= 1'b0;
      stb_oe  <= 1'b0;
    end else if (clk_en_i) begin
      stb_cnt <= next_stb_cnt;
      stb_lvl <= next_stb_lvl;
      stb_oe  <= next_stb_oe;
    end
  end

  // Reset line: only ever sink low, never drive high, so the supervisor
  // and the host can share the line through one pull-up
  always_comb begin
    next_rst_drv = assert_reset_i;
  end

  // Reset line drive register; released while in reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_drv <= 1'b0;
    end else if (clk_en_i) begin
      rst_drv <= next_rst_drv;
    end
  end

  // Pins: enables come straight from flip-flops; data of the open-drain
  // pins is a fixed low, the enable alone decides whether the pin sinks
  assign manual_reset_in_n_o  = 1'b0;
  assign manual_reset_oe_o    = man_drv;
  assign activity_strobe_in_o = stb_lvl;
  assign activity_oe_o        = stb_oe;
  assign reset_line_o         = 1'b0;
  assign reset_line_oe_o      = rst_drv;
  assign target_in_reset_o    = seen_low;
  assign manual_busy_o        = man_drv;
endmodule : sswd_host

/* test/sswd_host_properties.sv */
// Pin checks for the host controller
// Bound into every sswd_host instance
module sswd_host_properties #(
  parameter int MANUAL_CYC = 125
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic manual_req_i,
  input wire logic manual_busy_o,
  input wire logic manual_reset_oe_o,
  input wire logic manual_reset_in_n_o,
  input wire logic strobe_en_i,
  input wire logic activity_strobe_in_o,
  input wire logic activity_oe_o,
  input wire logic assert_reset_i,
  input wire logic reset_line_o,
  input wire logic reset_line_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  manual_take_a: assert property (
    clk_en_i && manual_req_i && !manual_busy_o |=> manual_reset_oe_o)
    else $error("manual request lost");
  manual_sink_a: assert property (
    manual_reset_oe_o |-> !manual_reset_in_n_o) else $error("manual not sunk");
  manual_width_a: assert property (
    $fell(manual_reset_oe_o) |-> $past(manual_reset_oe_o, MANUAL_CYC)) else $error("pulse short");
  strobe_hold_a: assert property ($changed(activity_strobe_in_o) |=>
    $stable(activity_strobe_in_o)[*8] ##1 $stable(activity_strobe_in_o)[*4]) else $error("hold");
  strobe_float_a: assert property (
    clk_en_i |=> activity_oe_o == $past(strobe_en_i)) else $error("strobe enable");
  line_sink_a: assert property (
    clk_en_i |=> reset_line_oe_o == $past(assert_reset_i) && reset_line_o == 1'b0)
    else $error("line not sunk");
endmodule : sswd_host_properties
bind sswd_host sswd_host_properties #(.MANUAL_CYC(MANUAL_CYC)) i_props (.*);

/* test/sswd_sup_model.sv */
// Behavioural supervisor facing the host
// Pin levels arrive resolved from the bench
module sswd_sup_model #(parameter int HOLD = 40, WD = 60, FALL = 10, FILT = 12) (
  input  wire logic clk_i,
  input  wire logic supply_ok_i, // Comparator with hysteresis
  input  wire logic man_n_i,     // Pulled up when released
  input  wire logic wdi_i,
  input  wire logic wdi_oe_i,    // Driven flag, low when floating
  output logic      sink_o);
  int hc = 0, wc = 0, fc = 0, mc = 0;
  logic wdi_q = 1'b0, cause;
  // Any cause sinks the line, then a full hold
  assign cause = fc >= FALL || mc >= FILT || wc >= WD;
  assign sink_o = cause || hc < HOLD;
  // Delay, filter, watchdog and hold counters
  always @(posedge clk_i) begin
    fc <= supply_ok_i ? 0 : fc + 1;
    mc <= man_n_i ? 0 : mc + 1;
    wdi_q <= wdi_i;
    wc <= (!wdi_oe_i || wdi_i != wdi_q || sink_o) ? 0 : wc + 1;
    hc <= cause ? 0 : (hc < HOLD ? hc + 1 : hc);
  end
endmodule : sswd_sup_model

/* test/tb_top.sv */
// Bench: host controller against the supervisor model
// Reset wire and manual input are open drain with pull-ups
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, en = 1, req = 0, sen = 0, ares = 0, sup = 1, told = 0;
  logic m_oe, s_lvl, s_oe, h_oe, d_sink, tgt;
  int   miscompares = 0, checks = 0, n;
  logic q[$];
  wire  line = !(h_oe || d_sink);
  wire  activity_strobe_in = s_oe ? s_lvl : !s_lvl;
  initial forever #4 clk = ~clk;
  sswd_host #(.STROBE_PERIOD(20)) i_sswd_host (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(en),
    .manual_req_i(req), .strobe_en_i(sen), .assert_reset_i(ares), .reset_line_i(line),
    .manual_reset_in_n_o(), .manual_reset_oe_o(m_oe), .activity_strobe_in_o(s_lvl),
    .activity_oe_o(s_oe), .reset_line_o(), .reset_line_oe_o(h_oe), .target_in_reset_o(tgt),
    .manual_busy_o());
  sswd_sup_model i_sswd_sup_model (.clk_i(clk), .supply_ok_i(sup), .man_n_i(!m_oe),
    .wdi_i(activity_strobe_in), .wdi_oe_i(s_oe), .sink_o(d_sink));
  // Each change of the seen reset state meets the oldest note
  always @(posedge clk) if (nrst && tgt !== told) begin
    told <= tgt;
    checks++;
    if (q.size() == 0 || q[0] !== tgt) begin
      miscompares++;
      $display("BAD %0t %h %h", $time, q.size() ? q[0] : 1'bx, tgt);
    end
    if (q.size()) void'(q.pop_front());
  end
  task automatic cyc(input int k); repeat (k) @(posedge clk); endtask : cyc
  task automatic note(); q.push_back(1'b1); q.push_back(1'b0); endtask : note
  // Bounded wait for all notes to be met
  task automatic settle(input string s);
    for (n = 0; q.size() && n < 3000; n++) @(posedge clk);
    if (q.size()) begin miscompares++; test_done(); end
    cyc(10);
    $display("end of %s", s);
  endtask : settle
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(12));
    note(); cyc(3); nrst <= 1; settle("power-up");
    sen <= 1; cyc(300); settle("fed");
    note(); req <= 1; cyc(1); req <= 0; cyc(2 + $urandom % 100); req <= 1; cyc(1); req <= 0;
    settle("manual");
    note(); en <= 0; cyc(70); en <= 1; settle("watchdog");
    sen <= 0; cyc(200); settle("float");
    sup <= 0; cyc(1 + $urandom % 8); sup <= 1; settle("dip");
    note(); sup <= 0; cyc(20 + $urandom % 40); sup <= 1; settle("supply");
    note(); ares <= 1; cyc(30); ares <= 0; settle("shared");
    test_done();
  end
endmodule : tb_top
